// ---- regen_loop_regs.svh ----
// Register offsets, field positions, reset values, message codes and timing counts.
`ifndef REGEN_LOOP_REGS_SVH
`define REGEN_LOOP_REGS_SVH

// =============================================================
// Register map
`define RLC_ADDR_W          4
`define RLC_OFF_CTRL        4'h0
`define RLC_OFF_STATUS      4'h4
`define RLC_OFF_HOLDCNT     4'h8

// =============================================================
// Control fields
`define RLC_CTRL_EN_BIT     0
`define RLC_CTRL_RST_BIT    1
`define RLC_CTRL_RESET      2'h3

// =============================================================
// Status fields
`define RLC_STAT_STATE_LSB  0
`define RLC_STAT_CLOSED_BIT 2
`define RLC_STAT_LINK_BIT   3

// =============================================================
// Operations channel message fields
`define RLC_ADDR_REGEN      2'h2
`define RLC_CODE_W          8
`define RLC_CODE_LOOP       8'h01
`define RLC_CODE_RTN        8'h02
`define RLC_CODE_HOLD       8'h03

// =============================================================
// Timing
`define RLC_CLK_MHZ         100
`define RLC_XCVR_RST_NS     1000
`define RLC_XCVR_RST_CYC    ((`RLC_XCVR_RST_NS * `RLC_CLK_MHZ + 999) / 1000)

`endif

// ---- regen_loop_pkg.sv ----
// Types shared by the regenerator loopback controller.
package regen_loop_pkg;

   typedef enum logic [1:0] {
      LOOP_NORMAL  = 2'b00,
      LOOP_CLOSING = 2'b01,
      LOOP_CLOSED  = 2'b10,
      LOOP_RELEASE = 2'b11
   } loop_state_e;

endpackage

// ---- reply_buffer.sv ----
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns

module reply_buffer #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 2
) (
   input  wire logic             clk_sys_i,
   input  wire logic             srst_i,
   input  wire logic             ce_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic [PW-1:0]    next_wr_ptr;
   logic [PW-1:0]    next_rd_ptr;
   logic [PW:0]      next_count;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign in_ready_o  = (count != (PW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];

   always_comb
   begin
      push        = ce_i && in_valid_i && in_ready_o;
      pop         = ce_i && out_valid_o && out_ready_i;
      next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
      next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule

// ---- regen_loopback_control.sv ----
// Regenerator transparent loopback controller.
`timescale 1ns/1ns
`include "regen_loop_regs.svh"

module regen_loopback_control #(
   parameter int DATA_W      = 8,
   parameter int IND_W       = 8,
   parameter int RST_CYCLES  = `RLC_XCVR_RST_CYC
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    srst_i,
   input  wire logic                    ce_i,
   input  wire logic [`RLC_ADDR_W-1:0]  reg_addr_i,
   input  wire logic [31:0]             reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic      [31:0]             reg_rdata_o,
   input  wire logic                    net_link_active_i,
   input  wire logic                    msg_valid_i,
   output logic                         msg_ready_o,
   input  wire logic [1:0]              msg_addr_i,
   input  wire logic [`RLC_CODE_W-1:0]  msg_code_i,
   output logic                         msg_local_o,
   output logic      [`RLC_CODE_W-1:0]  msg_local_code_o,
   output logic                         reply_valid_o,
   input  wire logic                    reply_ready_i,
   output logic      [1:0]              reply_addr_o,
   output logic      [`RLC_CODE_W-1:0]  reply_code_o,
   input  wire logic [DATA_W-1:0]       net_rx_data_i,
   input  wire logic [DATA_W-1:0]       cust_rx_data_i,
   output logic      [DATA_W-1:0]       net_tx_data_o,
   output logic      [DATA_W-1:0]       cust_tx_data_o,
   input  wire logic [IND_W-1:0]        net_rx_ind_i,
   input  wire logic [IND_W-1:0]        cust_rx_ind_i,
   input  wire logic [2:0]              regen_ind_i,
   output logic      [IND_W-1:0]        net_tx_ind_o,
   output logic                         loop_closed_o,
   output logic                         cust_xcvr_reset_o,
   output logic                         cust_xcvr_deact_o,
   output logic                         cust_startup_o
);

   localparam int CW = $clog2(RST_CYCLES + 1);

   // =============================================================
   // Register file
   logic [1:0]               ctrl;
   logic [15:0]              hold_cnt;
   logic [31:0]              next_rdata;
   logic [1:0]               next_ctrl;
   logic [15:0]              next_hold_cnt;

   // =============================================================
   // Loop state
   regen_loop_pkg::loop_state_e st;
   regen_loop_pkg::loop_state_e next_st;
   logic [CW-1:0]            tmr;
   logic [CW-1:0]            next_tmr;
   logic                     startup;
   logic                     next_startup;
   logic                     local_vld;
   logic                     next_local_vld;
   logic [`RLC_CODE_W-1:0]   local_code;
   logic [`RLC_CODE_W-1:0]   next_local_code;
   logic [DATA_W-1:0]        next_net_tx;
   logic [DATA_W-1:0]        next_cust_tx;
   logic [IND_W-1:0]         next_ind;
   logic                     buf_in_ready;
   logic                     take;
   logic                     for_me;
   logic                     hold_req;
   logic                     looping;

   function automatic logic is_code(input logic [`RLC_CODE_W-1:0] c,
                                    input logic [`RLC_CODE_W-1:0] ref_c);
      is_code = (c == ref_c);
   endfunction

   assign msg_ready_o       = buf_in_ready;
   assign take              = ce_i && msg_valid_i && buf_in_ready;
   assign for_me            = (msg_addr_i == `RLC_ADDR_REGEN);
   assign looping           = (st == regen_loop_pkg::LOOP_CLOSED)
                              || (st == regen_loop_pkg::LOOP_CLOSING);
   assign hold_req          = take && looping && !for_me;
   assign loop_closed_o     = looping;
   assign cust_xcvr_reset_o = (st == regen_loop_pkg::LOOP_CLOSING);
   assign cust_xcvr_deact_o = (st == regen_loop_pkg::LOOP_RELEASE);
   assign cust_startup_o    = startup;
   assign msg_local_o       = local_vld;
   assign msg_local_code_o  = local_code;

   // Hold answers toward the line side queue here; a full queue stalls the channel.
   reply_buffer #(
      .WIDTH (2 + `RLC_CODE_W),
      .DEPTH (2)
   ) u_reply_buffer (
      .clk_sys_i   (clk_sys_i),
      .srst_i      (srst_i),
      .ce_i        (ce_i),
      .in_valid_i  (hold_req),
      .in_ready_o  (buf_in_ready),
      .in_data_i   ({`RLC_ADDR_REGEN, `RLC_CODE_HOLD}),
      .out_valid_o (reply_valid_o),
      .out_ready_i (reply_ready_i),
      .out_data_o  ({reply_addr_o, reply_code_o})
   );

   // =============================================================
   // Register bus
   always_comb
   begin
      next_ctrl     = ctrl;
      next_hold_cnt = hold_cnt;
      next_rdata    = 32'h0;
      if (reg_wr_i && reg_addr_i == `RLC_OFF_CTRL)
      begin
         next_ctrl = reg_wdata_i[1:0];
      end
      if (reg_wr_i && reg_addr_i == `RLC_OFF_HOLDCNT)
      begin
         next_hold_cnt = hold_req ? 16'h1 : 16'h0;
      end
      else if (hold_req)
      begin
         next_hold_cnt = hold_cnt + 16'h1;
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `RLC_OFF_CTRL:
               next_rdata = {30'h0, ctrl};
            `RLC_OFF_STATUS:
            begin
               next_rdata[`RLC_STAT_STATE_LSB+:2]  = st;
               next_rdata[`RLC_STAT_CLOSED_BIT]    = looping;
               next_rdata[`RLC_STAT_LINK_BIT]      = net_link_active_i;
            end
            `RLC_OFF_HOLDCNT:
               next_rdata = {16'h0, hold_cnt};
            default:
               next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         ctrl        <= `RLC_CTRL_RESET;
         hold_cnt    <= 16'h0;
         reg_rdata_o <= 32'h0;
      end
      else if (ce_i)
      begin
         ctrl        <= next_ctrl;
         hold_cnt    <= next_hold_cnt;
         reg_rdata_o <= next_rdata;
      end
   end

   // =============================================================
   // Loop control
   always_comb
   begin
      next_st         = st;
      next_tmr        = tmr;
      next_startup    = 1'b0;
      next_local_vld  = 1'b0;
      next_local_code = local_code;
      // Regenerator-addressed messages other than loop control go to local processing.
      if (take && for_me && !is_code(msg_code_i, `RLC_CODE_LOOP)
          && !is_code(msg_code_i, `RLC_CODE_RTN))
      begin
         next_local_vld  = 1'b1;
         next_local_code = msg_code_i;
      end
      case (st)
         regen_loop_pkg::LOOP_NORMAL:
         begin
            if (take && for_me && is_code(msg_code_i, `RLC_CODE_LOOP)
                && net_link_active_i && ctrl[`RLC_CTRL_EN_BIT])
            begin
               if (ctrl[`RLC_CTRL_RST_BIT])
               begin
                  next_st  = regen_loop_pkg::LOOP_CLOSING;
                  next_tmr = CW'(RST_CYCLES);
               end
               else
               begin
                  next_st = regen_loop_pkg::LOOP_CLOSED;
               end
            end
         end
         regen_loop_pkg::LOOP_CLOSING:
         begin
            if (!net_link_active_i
                || (take && for_me && is_code(msg_code_i, `RLC_CODE_RTN)))
            begin
               next_st = regen_loop_pkg::LOOP_RELEASE;
            end
            else if (tmr <= CW'(1))
            begin
               next_st = regen_loop_pkg::LOOP_CLOSED;
            end
            else
            begin
               next_tmr = tmr - CW'(1);
            end
         end
         regen_loop_pkg::LOOP_CLOSED:
         begin
            if (!net_link_active_i
                || (take && for_me && is_code(msg_code_i, `RLC_CODE_RTN)))
            begin
               next_st = regen_loop_pkg::LOOP_RELEASE;
            end
         end
         regen_loop_pkg::LOOP_RELEASE:
         begin
            next_st      = regen_loop_pkg::LOOP_NORMAL;
            next_startup = net_link_active_i;
         end
         default:
            next_st = regen_loop_pkg::LOOP_NORMAL;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         st         <= regen_loop_pkg::LOOP_NORMAL;
         tmr        <= '0;
         startup    <= 1'b0;
         local_vld  <= 1'b0;
         local_code <= '0;
      end
      else if (ce_i)
      begin
         st         <= next_st;
         tmr        <= next_tmr;
         startup    <= next_startup;
         local_vld  <= next_local_vld;
         local_code <= next_local_code;
      end
   end

   // =============================================================
   // Data and indicator path
   always_comb
   begin
      next_cust_tx = net_rx_data_i;
      next_net_tx  = looping ? net_rx_data_i : cust_rx_data_i;
      next_ind     = looping ? net_rx_ind_i : cust_rx_ind_i;
      next_ind[2:0] = regen_ind_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         net_tx_data_o  <= '0;
         cust_tx_data_o <= '0;
         net_tx_ind_o   <= '0;
      end
      else if (ce_i)
      begin
         net_tx_data_o  <= next_net_tx;
         cust_tx_data_o <= next_cust_tx;
         net_tx_ind_o   <= next_ind;
      end
   end

   // =============================================================
   // Assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   AST_CLOSE_ON_CMD: assert property (
      (st == regen_loop_pkg::LOOP_NORMAL) && take && for_me
      && msg_code_i == `RLC_CODE_LOOP && net_link_active_i && ctrl == 2'h3
      |=> st == regen_loop_pkg::LOOP_CLOSING)
      else $error("Loop command did not start closing.");

   AST_RESET_WHILE_CLOSING: assert property (
      $rose(cust_xcvr_reset_o) && ce_i |-> ##1 cust_xcvr_reset_o)
      else $error("Customer transceiver reset too short.");

   AST_FORWARD_DATA: assert property (
      ce_i |=> cust_tx_data_o == $past(net_rx_data_i))
      else $error("Data not forwarded toward network unit.");

   AST_LOOP_DATA: assert property (
      ce_i && looping |=> net_tx_data_o == $past(net_rx_data_i))
      else $error("Looped data missing toward line unit.");

   AST_HOLD_REPLY: assert property (
      hold_req && !reply_valid_o |=> reply_valid_o && reply_addr_o == 2'h2
      && reply_code_o == `RLC_CODE_HOLD)
      else $error("Hold answer not issued.");

   AST_NO_HOLD_NORMAL: assert property (
      !loop_closed_o && !reply_valid_o |=> !reply_valid_o)
      else $error("Hold answer outside loopback.");

   AST_REGEN_IND: assert property (
      ce_i |=> net_tx_ind_o[2:0] == $past(regen_ind_i))
      else $error("Regenerator indicators not kept.");

   AST_RTN_DEACT: assert property (
      ce_i && st == regen_loop_pkg::LOOP_CLOSED && take && for_me
      && msg_code_i == `RLC_CODE_RTN |=> cust_xcvr_deact_o ##1 !loop_closed_o)
      else $error("Return to normal did not cancel loopback.");

   AST_STARTUP: assert property (
      ce_i && cust_xcvr_deact_o && net_link_active_i |=> cust_startup_o)
      else $error("Customer start-up not begun.");

   AST_LINK_DROP: assert property (
      ce_i && st == regen_loop_pkg::LOOP_CLOSED && !net_link_active_i
      |=> cust_xcvr_deact_o)
      else $error("Loop held after link loss.");

   COV_CLOSE: cover property (st == regen_loop_pkg::LOOP_CLOSING
      ##[1:200] st == regen_loop_pkg::LOOP_CLOSED);
   COV_HOLD: cover property (hold_req);
   COV_RELEASE_START: cover property (cust_xcvr_deact_o ##1 cust_startup_o);
   COV_STALL: cover property (msg_valid_i && !msg_ready_o);

endmodule

// ---- ltu_model.sv ----
// Line termination unit model: sends channel messages and takes hold answers.
`timescale 1ns/1ns
`include "regen_loop_regs.svh"

module ltu_model (
   input  wire logic                   clk_sys_i,
   input  wire logic                   msg_ready_i,
   input  wire logic                   reply_valid_i,
   input  wire logic                   stall_i,
   output logic                        msg_valid_o,
   output logic      [1:0]             msg_addr_o,
   output logic      [`RLC_CODE_W-1:0] msg_code_o,
   output logic                        reply_ready_o
);
   int taken = 0;

   initial
   begin
      msg_valid_o = 1'b0;
      msg_addr_o  = 2'h1;
      msg_code_o  = 8'hFF;
   end

   assign reply_ready_o = ~stall_i;

   always @(posedge clk_sys_i)
   begin
      if (reply_valid_i && reply_ready_o)
      begin
         taken <= taken + 1;
      end
   end

   // Holds one message until it is taken or 50 more cycles pass; the lines show inverted values between messages.
   task automatic send(input logic [1:0] a, input logic [`RLC_CODE_W-1:0] c, output bit ok);
      int n;
      n = 0;
      msg_valid_o <= 1'b1;
      msg_addr_o  <= a;
      msg_code_o  <= c;
      @(posedge clk_sys_i);
      while (!msg_ready_i && n < 50)
      begin
         n++;
         @(posedge clk_sys_i);
      end
      ok = msg_ready_i;
      #1;
      msg_valid_o <= 1'b0;
      msg_addr_o  <= ~a;
      msg_code_o  <= ~c;
   endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the regenerator loopback controller.
`timescale 1ns/1ns
`include "regen_loop_regs.svh"

module tb_top;
   localparam int RST = 2;
   logic                   clk_sys_i = 1'b0;
   logic                   srst_i = 1'b1;
   logic                   ce_i = 1'b1;
   logic [3:0]             reg_addr_i = 4'h0;
   logic [31:0]            reg_wdata_i = 32'h0;
   logic                   reg_wr_i = 1'b0;
   logic                   reg_rd_i = 1'b0;
   logic [31:0]            reg_rdata_o;
   logic                   net_link_active_i = 1'b0;
   logic                   msg_valid_i;
   logic                   msg_ready_o;
   logic [1:0]             msg_addr_i;
   logic [`RLC_CODE_W-1:0] msg_code_i;
   logic                   msg_local_o;
   logic [`RLC_CODE_W-1:0] msg_local_code_o;
   logic                   reply_valid_o;
   logic                   reply_ready_i;
   logic [1:0]             reply_addr_o;
   logic [`RLC_CODE_W-1:0] reply_code_o;
   logic [7:0]             net_rx_data_i = 8'hA5;
   logic [7:0]             cust_rx_data_i = 8'h3C;
   logic [7:0]             net_tx_data_o;
   logic [7:0]             cust_tx_data_o;
   logic [7:0]             net_rx_ind_i = 8'hAA;
   logic [7:0]             cust_rx_ind_i = 8'h55;
   logic [2:0]             regen_ind_i = 3'h6;
   logic [7:0]             net_tx_ind_o;
   logic                   loop_closed_o;
   logic                   cust_xcvr_reset_o;
   logic                   cust_xcvr_deact_o;
   logic                   cust_startup_o;
   logic                   stall = 1'b0;
   int                     miscompares = 0;
   int                     total_checks = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   regen_loopback_control #(.DATA_W(8), .IND_W(8), .RST_CYCLES(RST)) u_regen_loopback_control (
      .clk_sys_i, .srst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .net_link_active_i, .msg_valid_i, .msg_ready_o, .msg_addr_i, .msg_code_i, .msg_local_o,
      .msg_local_code_o, .reply_valid_o, .reply_ready_i, .reply_addr_o, .reply_code_o,
      .net_rx_data_i, .cust_rx_data_i, .net_tx_data_o, .cust_tx_data_o, .net_rx_ind_i,
      .cust_rx_ind_i, .regen_ind_i, .net_tx_ind_o, .loop_closed_o, .cust_xcvr_reset_o,
      .cust_xcvr_deact_o, .cust_startup_o);

   ltu_model u_ltu_model (
      .clk_sys_i, .msg_ready_i(msg_ready_o), .reply_valid_i(reply_valid_o), .stall_i(stall),
      .msg_valid_o(msg_valid_i), .msg_addr_o(msg_addr_i), .msg_code_o(msg_code_i),
      .reply_ready_o(reply_ready_i));

   // =============================================================
   // Shared tasks
   task automatic finish_test;
      if (miscompares == 0 && total_checks > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      cyc();
      reg_wr_i <= 1'b0;
      cyc();
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      cyc();
      reg_rd_i <= 1'b0;
      d = reg_rdata_o;
      cyc();
   endtask

   // A message the design does not take within 50 more cycles ends the run.
   task automatic msg(input logic [1:0] a, input logic [7:0] c);
      bit ok;
      u_ltu_model.send(a, c, ok);
      if (!ok)
      begin
         chk("msg_taken", 32'h1, 32'h0);
         finish_test();
      end
   endtask

   // =============================================================
   // Scenarios
   task automatic t_regs;
      logic [31:0] d;
      logic [3:0]  adr [4] = '{`RLC_OFF_CTRL, `RLC_OFF_STATUS, `RLC_OFF_HOLDCNT, 4'hC};
      logic [31:0] exp [4] = '{32'h3, 32'h0, 32'h0, 32'h0};
      reg_write(4'hC, 32'hFFFFFFFF);
      for (int i = 0; i < 4; i++)
      begin
         reg_read(adr[i], d);
         chk("reg_reset", exp[i], d);
      end
   endtask

   task automatic t_refuse;
      msg(2'h2, `RLC_CODE_LOOP);
      chk("closed_no_link", 1'b0, loop_closed_o);
      chk("tx_normal", 8'h3C, net_tx_data_o);
      chk("ind_normal", 8'h56, net_tx_ind_o);
      net_link_active_i <= 1'b1;
      cyc();
   endtask

   task automatic t_close;
      int n;
      logic [31:0] d;
      n = 0;
      msg(2'h2, `RLC_CODE_LOOP);
      chk("closed", 1'b1, loop_closed_o);
      chk("xcvr_reset", 1'b1, cust_xcvr_reset_o);
      while (cust_xcvr_reset_o && n < 20)
      begin
         cyc();
         n++;
      end
      chk("reset_len", RST, n);
      chk("still_closed", 1'b1, loop_closed_o);
      chk("tx_looped", 8'hA5, net_tx_data_o);
      chk("tx_forward", 8'hA5, cust_tx_data_o);
      chk("ind_looped", 8'hAE, net_tx_ind_o);
      reg_read(`RLC_OFF_STATUS, d);
      chk("status_closed", 32'hE, d);
   endtask

   task automatic t_local;
      msg(2'h2, 8'h40);
      chk("local", 1'b1, msg_local_o);
      chk("local_code", 8'h40, msg_local_code_o);
      cyc();
      chk("local_end", 1'b0, msg_local_o);
      chk("local_closed", 1'b1, loop_closed_o);
   endtask

   task automatic t_hold;
      logic [31:0] d;
      stall <= 1'b1;
      msg(2'h0, 8'h11);
      cyc();
      msg(2'h3, 8'h22);
      chk("queue_full", 1'b0, msg_ready_o);
      chk("hold_valid", 1'b1, reply_valid_o);
      chk("hold_addr", `RLC_ADDR_REGEN, reply_addr_o);
      chk("hold_code", `RLC_CODE_HOLD, reply_code_o);
      stall <= 1'b0;
      repeat (3) cyc();
      chk("hold_taken", 32'd2, u_ltu_model.taken);
      chk("queue_empty", 1'b0, reply_valid_o);
      reg_read(`RLC_OFF_HOLDCNT, d);
      chk("holdcnt", 32'h2, d);
      reg_write(`RLC_OFF_HOLDCNT, 32'h0);
      reg_read(`RLC_OFF_HOLDCNT, d);
      chk("holdcnt_clear", 32'h0, d);
   endtask

   task automatic t_release;
      msg(2'h2, `RLC_CODE_RTN);
      chk("deact", 1'b1, cust_xcvr_deact_o);
      chk("open", 1'b0, loop_closed_o);
      cyc();
      chk("startup", 1'b1, cust_startup_o);
      chk("deact_end", 1'b0, cust_xcvr_deact_o);
      chk("tx_back", 8'h3C, net_tx_data_o);
   endtask

   task automatic t_link_loss;
      reg_write(`RLC_OFF_CTRL, 32'h1);
      msg(2'h2, `RLC_CODE_LOOP);
      chk("closed_direct", 1'b1, loop_closed_o);
      chk("no_reset", 1'b0, cust_xcvr_reset_o);
      net_link_active_i <= 1'b0;
      cyc();
      chk("loss_deact", 1'b1, cust_xcvr_deact_o);
      chk("loss_open", 1'b0, loop_closed_o);
      cyc();
      chk("no_startup", 1'b0, cust_startup_o);
   endtask

   task automatic t_disable;
      logic [31:0] d;
      net_link_active_i <= 1'b1;
      reg_write(`RLC_OFF_CTRL, 32'h0);
      msg(2'h2, `RLC_CODE_LOOP);
      chk("closed_disabled", 1'b0, loop_closed_o);
      srst_i <= 1'b1;
      repeat (2) cyc();
      srst_i <= 1'b0;
      cyc();
      chk("rst_ready", 1'b1, msg_ready_o);
      chk("rst_closed", 1'b0, loop_closed_o);
      ce_i <= 1'b0;
      reg_write(`RLC_OFF_CTRL, 32'h0);
      ce_i <= 1'b1;
      reg_read(`RLC_OFF_CTRL, d);
      chk("ctrl_frozen", 32'h3, d);
   endtask

   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      cyc();
      t_regs();
      t_refuse();
      t_close();
      t_local();
      t_hold();
      t_release();
      t_link_loss();
      t_disable();
      finish_test();
   end
endmodule
